/* File: shared/flash_front_consts.vh */
// opcodes, status layout and timing for the serial flash front end
`ifndef FLASH_FRONT_CONSTS_VH
`define FLASH_FRONT_CONSTS_VH
`define OP_WREN      8'h06
`define OP_WRDI      8'h04
`define OP_RDSR_LOW  8'h05
`define OP_RDSR_HIGH 8'h35
`define OP_WRSR      8'h01
`define OP_PROG      8'h02
`define OP_SEC_ERASE 8'h20
`define OP_BLK_ERASE 8'hD8
`define OP_CHIP_ER_A 8'hC7
`define OP_CHIP_ER_B 8'h60
`define OP_SUSPEND   8'h75
`define OP_PDOWN     8'hB9
`define OP_PD_REL    8'hAB
`define OP_READ      8'h03
`define OP_FAST      8'h0B
`define OP_DUAL_OUT  8'h3B
`define OP_DUAL_IO   8'hBB
`define OP_QUAD_OUT  8'h6B
`define OP_QUAD_IO   8'hEB
// status bit positions, low byte then high byte
`define SR_BUSY      0
`define SR_WPL       1
`define SR_BP0       2
`define SR_TB        5
`define SR_SEC       6
`define SR_LOCK_LO   7
`define SR_LOCK_HI   0
`define SR_QUAD      1
// dummy clocks after the address
`define DUMMY_FAST   4'h8
`define DUMMY_DUALIO 4'h4
`define DUMMY_QUADIO 4'h6
// array geometry
`define ARRAY_TOP    22'h200000
`define SECTOR_SIZE  22'h001000
`define BLOCK_SIZE   22'h010000
// timing
`define CLK_MHZ      25
`define TPUW_NS      10000
`define TW_NS        10000
`define TPUW_CYC     ((`TPUW_NS * `CLK_MHZ + 999) / 1000)
`define TW_CYC       ((`TW_NS * `CLK_MHZ + 999) / 1000)
`define FIFO_DEPTH   8
`define FIFO_AW      3
`endif

/* File: verilog/flash_front.v */
// serial flash bus front end with status register and page data buffer
//
// Function
// - single lane: host bits sampled on rising clock, answer driven on falling clock
// - clock modes 0 and 3 both work; only edges inside select matter
// - dual read opcodes use lanes zero and one
// - quad read opcodes use all four lanes, protect and pause pins included
// - quad opcodes run only with quad enable set; then pins become lanes
// - write-protect pin is active low and gates status writes
// - pause starts with pause pin low, select low, at low clock
// - pause ends at low clock after pause pin rises, state kept
// - paused: outputs released, clock and input lanes ignored
// - pause works only with quad enable clear, outside quad transfers
// - during reset nothing runs; write-type opcodes refused for power-up delay
// - write enable must precede program, erase and status write
// - write permit clears at reset, write disable and op completion
// - power-down ignores all but release
// - busy bit 0 set during ops; only status read and suspend accepted
// - write permit latch is status bit 1, set by write enable
// - three protect range bits written by status write, default zero
// - top/bottom select picks end of array, default top
// - small unit bit picks 4KB sectors or 64KB blocks
// - status write needs write permit and lock settings allowing it
// - lock pair: 00 soft, 01 pin gated, 10 and 11 until power cycle
// - quad enable is status bit 9, default zero
`include "flash_front_consts.vh"

module fifo_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_sys_rst,
  // fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign o_in_ready  = (count_reg != DEPTH[AW:0]);
  assign o_out_valid = (count_reg != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module flash_front #(
  parameter TPUW_CYC = `TPUW_CYC,
  parameter TW_CYC   = `TW_CYC
) (
  // clock and power-on reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // serial bus pins
  input  wire        i_cs_n,
  input  wire        i_sclk,
  input  wire        i_lane_zero,
  input  wire        i_lane_one,
  input  wire        i_lane_two,
  input  wire        i_lane_three,
  output reg         o_lane_zero,
  output reg         o_lane_zero_oe,
  output reg         o_lane_one,
  output reg         o_lane_one_oe,
  output reg         o_lane_two,
  output reg         o_lane_two_oe,
  output reg         o_lane_three,
  output reg         o_lane_three_oe,
  // array command port
  output reg         o_cmd_valid,
  output reg  [7:0]  o_cmd_code,
  output reg  [23:0] o_cmd_addr,
  input  wire        i_op_done,
  // array read port
  output reg  [23:0] o_rd_addr,
  input  wire [7:0]  i_rd_data,
  // page program data
  output wire        o_wr_valid,
  input  wire        i_wr_ready,
  output wire [7:0]  o_wr_data
);
  localparam PH_CMD = 3'h0;
  localparam PH_ADR = 3'h1;
  localparam PH_DUM = 3'h2;
  localparam PH_OUT = 3'h3;
  localparam PH_IN  = 3'h4;
  localparam PH_IGN = 3'h5;

  reg  [5:0]  s1_reg;
  reg  [5:0]  s2_reg;
  reg         sclk_d_reg;
  reg         cs_d_reg;
  reg  [2:0]  ph_reg;
  reg  [4:0]  cnt_reg;
  reg  [2:0]  tot_reg;
  reg  [23:0] rx_reg;
  reg  [7:0]  op_reg;
  reg  [2:0]  aw_reg;
  reg  [2:0]  dw_reg;
  reg  [3:0]  dum_reg;
  reg  [7:0]  tx_reg;
  reg  [2:0]  txc_reg;
  reg  [1:0]  nbytes_reg;
  reg  [15:0] wrsr_reg;
  reg         ok_reg;
  reg         paused_reg;
  reg         drive_reg;
  reg         push_reg;
  reg  [7:0]  push_data_reg;
  reg  [2:0]  bp_reg;
  reg         tb_reg;
  reg         sec_reg;
  reg         lock_lo_reg;
  reg         lock_hi_reg;
  reg         quad_reg;
  reg         wpl_reg;
  reg         busy_reg;
  reg         tw_run_reg;
  reg         pd_reg;
  reg  [15:0] puw_reg;
  reg  [15:0] tw_reg;
  reg  [7:0]  st_low;
  reg  [7:0]  st_high;
  reg  [23:0] rx_next;
  reg  [7:0]  byte_src;
  reg  [3:0]  obits;
  reg  [2:0]  w;
  wire        cs_s    = s2_reg[5];
  wire        sclk_s  = s2_reg[4];
  wire        l3_s    = s2_reg[3];
  wire        l2_s    = s2_reg[2];
  wire        l1_s    = s2_reg[1];
  wire        l0_s    = s2_reg[0];
  wire        quad_op = (op_reg == `OP_QUAD_OUT) | (op_reg == `OP_QUAD_IO);
  wire        lockout = (puw_reg != 16'h0000);
  wire        fifo_rdy;
  // pause pin only counts when it is not a data lane
  wire        hold_req = ~quad_reg & ~quad_op & ~l3_s & ~cs_s;
  // clock low: enter or leave pause now; clock high: wait for its fall
  wire        paused_next = cs_s ? 1'b0 : (sclk_s ? paused_reg : hold_req);
  wire        active = ~cs_s & ~paused_reg;
  wire        rise = active & sclk_s & ~sclk_d_reg;
  wire        fall = active & ~sclk_s & sclk_d_reg;
  wire        cs_rise = cs_s & ~cs_d_reg;
  wire [7:0]  op_in = {rx_reg[6:0], l0_s};
  // pin gate: protect pin is a data lane under quad enable, so it counts as high
  wire        lock_ok = ~lock_hi_reg & (~lock_lo_reg | quad_reg | l2_s);

  function prot_hit;
    input [23:0] a;
    input [2:0]  bp;
    input        tb;
    input        sec;
    reg   [21:0] size;
    begin
      size = 22'h000000;
      if (sec) begin
        size = `SECTOR_SIZE << (bp[2] ? 3'h3 : bp - 3'h1);
      end else begin
        size = `BLOCK_SIZE << (bp - 3'h1);
      end
      if (bp == 3'h0) begin
        prot_hit = 1'b0;
      end else if (bp[2:1] == 2'b11) begin
        prot_hit = 1'b1;
      end else if (tb) begin
        prot_hit = ({1'b0, a[20:0]} < size);
      end else begin
        prot_hit = ({1'b0, a[20:0]} >= (`ARRAY_TOP - size));
      end
    end
  endfunction

  always @* begin
    st_low = 8'h00;
    st_low[`SR_BUSY] = busy_reg;
    st_low[`SR_WPL] = wpl_reg;
    st_low[`SR_BP0 +: 3] = bp_reg;
    st_low[`SR_TB] = tb_reg;
    st_low[`SR_SEC] = sec_reg;
    st_low[`SR_LOCK_LO] = lock_lo_reg;
    st_high = 8'h00;
    st_high[`SR_LOCK_HI] = lock_hi_reg;
    st_high[`SR_QUAD] = quad_reg;
    w = (ph_reg == PH_ADR) ? aw_reg : 3'h1;
    case (w)
      3'h4: rx_next = {rx_reg[19:0], l3_s, l2_s, l1_s, l0_s};
      3'h2: rx_next = {rx_reg[21:0], l1_s, l0_s};
      default: rx_next = {rx_reg[22:0], l0_s};
    endcase
    if (op_reg == `OP_RDSR_LOW) begin
      byte_src = st_low;
    end else if (op_reg == `OP_RDSR_HIGH) begin
      byte_src = st_high;
    end else begin
      byte_src = i_rd_data;
    end
    obits = (txc_reg == 3'h0) ? byte_src[7:4] : tx_reg[7:4];
  end

  fifo_buffer #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) page_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push_reg),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (push_data_reg),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (o_wr_data)
  );

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_reg <= 6'h3F;
      s2_reg <= 6'h3F;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      ph_reg <= PH_CMD;
      cnt_reg <= 5'h00;
      tot_reg <= 3'h0;
      rx_reg <= 24'h000000;
      op_reg <= 8'h00;
      aw_reg <= 3'h1;
      dw_reg <= 3'h1;
      dum_reg <= 4'h0;
      tx_reg <= 8'h00;
      txc_reg <= 3'h0;
      nbytes_reg <= 2'h0;
      wrsr_reg <= 16'h0000;
      ok_reg <= 1'b0;
      paused_reg <= 1'b0;
      drive_reg <= 1'b0;
      push_reg <= 1'b0;
      push_data_reg <= 8'h00;
      bp_reg <= 3'h0;
      tb_reg <= 1'b0;
      sec_reg <= 1'b0;
      lock_lo_reg <= 1'b0;
      lock_hi_reg <= 1'b0;
      quad_reg <= 1'b0;
      wpl_reg <= 1'b0;
      busy_reg <= 1'b0;
      tw_run_reg <= 1'b0;
      pd_reg <= 1'b0;
      puw_reg <= TPUW_CYC[15:0];
      tw_reg <= 16'h0000;
      o_lane_zero <= 1'b0;
      o_lane_zero_oe <= 1'b0;
      o_lane_one <= 1'b0;
      o_lane_one_oe <= 1'b0;
      o_lane_two <= 1'b0;
      o_lane_two_oe <= 1'b0;
      o_lane_three <= 1'b0;
      o_lane_three_oe <= 1'b0;
      o_cmd_valid <= 1'b0;
      o_cmd_code <= 8'h00;
      o_cmd_addr <= 24'h000000;
      o_rd_addr <= 24'h000000;
    end else begin
      s1_reg <= {i_cs_n, i_sclk, i_lane_three, i_lane_two, i_lane_one, i_lane_zero};
      s2_reg <= s1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_s;
      paused_reg <= paused_next;
      o_cmd_valid <= 1'b0;
      push_reg <= 1'b0;
      if (lockout) begin
        puw_reg <= puw_reg - 16'h0001;
      end
      // completion of a status write or an array operation
      if (tw_run_reg) begin
        if (tw_reg == 16'h0001) begin
          tw_run_reg <= 1'b0;
          busy_reg <= 1'b0;
          wpl_reg <= 1'b0;
        end
        tw_reg <= tw_reg - 16'h0001;
      end else if (busy_reg & i_op_done) begin
        busy_reg <= 1'b0;
        wpl_reg <= 1'b0;
      end
      if (rise) begin
        tot_reg <= tot_reg + 3'h1;
        rx_reg <= rx_next;
        cnt_reg <= cnt_reg + {2'b00, w};
        case (ph_reg)
          PH_CMD: begin
            if (cnt_reg == 5'h07) begin
              op_reg <= op_in;
              cnt_reg <= 5'h00;
              ok_reg <= 1'b0;
              ph_reg <= PH_IGN;
              aw_reg <= 3'h1;
              dw_reg <= 3'h1;
              dum_reg <= 4'h0;
              nbytes_reg <= 2'h0;
              if (pd_reg) begin
                ok_reg <= (op_in == `OP_PD_REL);
              end else if (busy_reg) begin
                ok_reg <= (op_in == `OP_SUSPEND);
                if ((op_in == `OP_RDSR_LOW) | (op_in == `OP_RDSR_HIGH)) begin
                  ph_reg <= PH_OUT;
                end
              end else begin
                case (op_in)
                  `OP_RDSR_LOW, `OP_RDSR_HIGH: ph_reg <= PH_OUT;
                  `OP_WRSR: begin
                    ok_reg <= ~lockout;
                    ph_reg <= PH_IN;
                  end
                  `OP_WREN, `OP_CHIP_ER_A, `OP_CHIP_ER_B: ok_reg <= ~lockout;
                  `OP_WRDI, `OP_PDOWN: ok_reg <= 1'b1;
                  `OP_PROG, `OP_SEC_ERASE, `OP_BLK_ERASE, `OP_READ: ph_reg <= PH_ADR;
                  `OP_FAST, `OP_DUAL_OUT: begin
                    ph_reg <= PH_ADR;
                    dum_reg <= `DUMMY_FAST;
                    dw_reg <= (op_in == `OP_DUAL_OUT) ? 3'h2 : 3'h1;
                  end
                  `OP_DUAL_IO: begin
                    ph_reg <= PH_ADR;
                    aw_reg <= 3'h2;
                    dw_reg <= 3'h2;
                    dum_reg <= `DUMMY_DUALIO;
                  end
                  `OP_QUAD_OUT, `OP_QUAD_IO: begin
                    if (quad_reg) begin
                      ph_reg <= PH_ADR;
                      aw_reg <= (op_in == `OP_QUAD_IO) ? 3'h4 : 3'h1;
                      dw_reg <= 3'h4;
                      dum_reg <= (op_in == `OP_QUAD_IO) ? `DUMMY_QUADIO : `DUMMY_FAST;
                    end
                  end
                  default: ph_reg <= PH_IGN;
                endcase
              end
            end
          end
          PH_ADR: begin
            if ((cnt_reg + {2'b00, w}) == 5'h18) begin
              cnt_reg <= 5'h00;
              o_rd_addr <= rx_next;
              o_cmd_addr <= rx_next;
              // protected or unpermitted writes are dropped here
              ok_reg <= ~lockout & wpl_reg & ~prot_hit(rx_next, bp_reg, tb_reg, sec_reg);
              if (op_reg == `OP_PROG) begin
                ph_reg <= PH_IN;
              end else if ((op_reg == `OP_SEC_ERASE) | (op_reg == `OP_BLK_ERASE)) begin
                ph_reg <= PH_IGN;
              end else begin
                ph_reg <= (dum_reg == 4'h0) ? PH_OUT : PH_DUM;
              end
            end
          end
          PH_DUM: begin
            dum_reg <= dum_reg - 4'h1;
            if (dum_reg == 4'h1) begin
              ph_reg <= PH_OUT;
            end
          end
          PH_IN: begin
            if (cnt_reg[2:0] == 3'h7) begin
              if (nbytes_reg != 2'h2) begin
                nbytes_reg <= nbytes_reg + 2'h1;
              end
              wrsr_reg <= {wrsr_reg[7:0], op_in};
              // a full buffer loses the byte: the host cannot be stalled
              push_reg <= (op_reg == `OP_PROG) & ok_reg & fifo_rdy;
              push_data_reg <= op_in;
            end
          end
          default: ph_reg <= ph_reg;
        endcase
      end
      if (fall & (ph_reg == PH_OUT)) begin
        drive_reg <= 1'b1;
        if (txc_reg == 3'h0) begin
          tx_reg <= byte_src << dw_reg;
          txc_reg <= (dw_reg == 3'h4) ? 3'h1 : ((dw_reg == 3'h2) ? 3'h3 : 3'h7);
          if ((op_reg != `OP_RDSR_LOW) & (op_reg != `OP_RDSR_HIGH)) begin
            o_rd_addr <= o_rd_addr + 24'h000001;
          end
        end else begin
          tx_reg <= tx_reg << dw_reg;
          txc_reg <= txc_reg - 3'h1;
        end
        case (dw_reg)
          3'h4: {o_lane_three, o_lane_two, o_lane_one, o_lane_zero} <= obits;
          3'h2: {o_lane_one, o_lane_zero} <= obits[3:2];
          default: o_lane_one <= obits[3];
        endcase
      end
      o_lane_one_oe <= drive_reg & ~paused_next;
      o_lane_zero_oe <= drive_reg & ~paused_next & (dw_reg != 3'h1);
      o_lane_two_oe <= drive_reg & ~paused_next & (dw_reg == 3'h4);
      o_lane_three_oe <= drive_reg & ~paused_next & (dw_reg == 3'h4);
      if (cs_rise) begin
        ph_reg <= PH_CMD;
        cnt_reg <= 5'h00;
        tot_reg <= 3'h0;
        txc_reg <= 3'h0;
        drive_reg <= 1'b0;
        o_lane_zero_oe <= 1'b0;
        o_lane_one_oe <= 1'b0;
        o_lane_two_oe <= 1'b0;
        o_lane_three_oe <= 1'b0;
        // write-type work commits only on a byte boundary
        if (ok_reg & (tot_reg == 3'h0)) begin
          case (op_reg)
            `OP_WREN: wpl_reg <= 1'b1;
            `OP_WRDI: wpl_reg <= 1'b0;
            `OP_PDOWN: pd_reg <= 1'b1;
            `OP_PD_REL: pd_reg <= 1'b0;
            `OP_WRSR: begin
              if (wpl_reg & lock_ok & (nbytes_reg != 2'h0)) begin
                busy_reg <= 1'b1;
                tw_run_reg <= 1'b1;
                tw_reg <= TW_CYC[15:0];
                if (nbytes_reg == 2'h1) begin
                  {lock_lo_reg, sec_reg, tb_reg, bp_reg} <= wrsr_reg[7:2];
                end else begin
                  {lock_lo_reg, sec_reg, tb_reg, bp_reg} <= wrsr_reg[15:10];
                  {quad_reg, lock_hi_reg} <= wrsr_reg[1:0];
                end
              end
            end
            `OP_CHIP_ER_A, `OP_CHIP_ER_B: begin
              if (wpl_reg & (bp_reg == 3'h0)) begin
                busy_reg <= 1'b1;
                o_cmd_valid <= 1'b1;
                o_cmd_code <= op_reg;
              end
            end
            `OP_PROG, `OP_SEC_ERASE, `OP_BLK_ERASE: begin
              busy_reg <= 1'b1;
              o_cmd_valid <= 1'b1;
              o_cmd_code <= op_reg;
            end
            `OP_SUSPEND: begin
              o_cmd_valid <= 1'b1;
              o_cmd_code <= op_reg;
            end
            default: pd_reg <= pd_reg;
          endcase
        end
      end
    end
  end
endmodule

/* File: tb/flash_front_chk.sv */
// assertion checker bound to the serial flash front end
`include "flash_front_consts.vh"
module flash_front_chk #(
  parameter TPUW_CYC = 4
) (
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire       i_cs_n,
  input wire       i_sclk,
  input wire       i_lane_three,
  input wire       i_op_done,
  input wire       i_wr_ready,
  input wire       o_lane_zero_oe,
  input wire       o_lane_one,
  input wire       o_lane_one_oe,
  input wire       o_lane_two_oe,
  input wire       o_lane_three_oe,
  input wire       o_cmd_valid,
  input wire [7:0] o_cmd_code,
  input wire       o_wr_valid,
  input wire [7:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        busy_seen;
  logic        sclk_q;
  logic [3:0]  fall_age;
  int unsigned up_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // raw pin history, so the output latency is measured from the real edge
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_seen <= 1'b0;
      sclk_q    <= 1'b0;
      fall_age  <= 4'hF;
      up_cnt    <= 0;
    end else begin
      if (o_cmd_valid && o_cmd_code != `OP_SUSPEND) busy_seen <= 1'b1;
      else if (i_op_done) busy_seen <= 1'b0;
      sclk_q   <= i_sclk;
      fall_age <= (sclk_q && !i_sclk) ? 4'h0 : ((fall_age == 4'hF) ? 4'hF : fall_age + 4'h1);
      if (up_cnt < 1000) up_cnt <= up_cnt + 1;
    end
  end
  AST_DESELECT_QUIET: assert property (i_cs_n [*6] |-> !o_lane_one_oe && !o_lane_zero_oe)
    else $error("lanes driven while deselected");
  AST_QUAD_ALL_LANES: assert property (o_lane_two_oe |-> o_lane_three_oe && o_lane_zero_oe && o_lane_one_oe)
    else $error("quad output without all four lanes");
  AST_DUAL_PAIR: assert property (o_lane_zero_oe |-> o_lane_one_oe)
    else $error("lane zero driven without lane one");
  AST_PAUSE_RELEASE: assert property ((!i_cs_n && !i_lane_three && !i_sclk && !o_lane_three_oe) [*8]
    |-> !o_lane_one_oe)
    else $error("output still driven in pause");
  AST_BUSY_REFUSE: assert property (busy_seen && o_cmd_valid |-> o_cmd_code == `OP_SUSPEND)
    else $error("array op committed while busy");
  AST_OUT_ON_FALL: assert property (o_lane_one_oe && $past(o_lane_one_oe) && $changed(o_lane_one)
    |-> fall_age <= 4'h6)
    else $error("output bit changed away from a falling clock");
  AST_LOCKOUT: assert property (up_cnt < TPUW_CYC |-> !o_cmd_valid)
    else $error("array op during power-up lockout");
  AST_FIFO_HOLD: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_data))
    else $error("page byte lost while stalled");
  AST_CMD_PULSE: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("commit pulse longer than one cycle");
endmodule
bind flash_front flash_front_chk #(.TPUW_CYC(TPUW_CYC)) chk (.i_clk, .i_sys_rst, .i_cs_n, .i_sclk, .i_lane_three,
  .i_op_done, .i_wr_ready, .o_lane_zero_oe, .o_lane_one, .o_lane_one_oe, .o_lane_two_oe, .o_lane_three_oe,
  .o_cmd_valid, .o_cmd_code, .o_wr_valid, .o_wr_data);

/* File: tb/spi_host_model.sv */
// serial bus host model: mode 0 byte transfers, select, protect and pause pins
module spi_host_model (
  // clock
  input  wire  i_clk,
  // device answer
  input  wire  i_miso,
  // bus pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_wp_n,
  output logic o_hold_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs_n   = 1'b1;
    o_sclk   = 1'b0;
    o_mosi   = 1'b0;
    o_wp_n   = 1'b1;
    o_hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic sel;
    @(posedge i_clk) o_cs_n <= 1'b0;
    tick(4);
  endtask
  // clock brought low before select rises
  task automatic desel;
    @(posedge i_clk) o_sclk <= 1'b0;
    tick(4);
    o_cs_n <= 1'b1;
    tick(8);
  endtask
  // msb first, half period of four system cycles
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk) o_sclk <= 1'b0;
      o_mosi <= tx[i];
      tick(4);
      o_sclk <= 1'b1;
      tick(3);
      @(negedge i_clk);
      rx[i] = i_miso;
    end
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the serial flash front end
`include "flash_front_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_op_done = 1'b0;
  logic        i_wr_ready = 1'b0;
  logic [7:0]  i_rd_data;
  logic        i_cs_n, i_sclk, i_lane_zero, i_lane_one, i_lane_two, i_lane_three;
  logic        mosi, wp_n, hold_n;
  wire         o_lane_zero, o_lane_zero_oe, o_lane_one, o_lane_one_oe, o_cmd_valid, o_wr_valid;
  wire         o_lane_two, o_lane_two_oe, o_lane_three, o_lane_three_oe;
  wire [7:0]   o_cmd_code, o_wr_data;
  wire [23:0]  o_cmd_addr, o_rd_addr;
  int          fails = 0;
  int          total_checks = 0;
  int          cmd_cnt = 0;
  logic [7:0]  last_code;
  logic [23:0] last_addr;
  assign i_lane_zero  = o_lane_zero_oe ? o_lane_zero : mosi;
  // nobody pulls this line, so an undriven lane shows the inverse of its last bit
  assign i_lane_one   = o_lane_one_oe ? o_lane_one : ~o_lane_one;
  assign i_lane_two   = o_lane_two_oe ? o_lane_two : wp_n;
  assign i_lane_three = o_lane_three_oe ? o_lane_three : hold_n;
  spi_host_model host (.i_clk, .i_miso(i_lane_one), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_mosi(mosi),
    .o_wp_n(wp_n), .o_hold_n(hold_n));
  flash_front #(.TPUW_CYC(200), .TW_CYC(4)) dut (.i_clk, .i_sys_rst, .i_cs_n, .i_sclk, .i_lane_zero, .i_lane_one,
    .i_lane_two, .i_lane_three, .o_lane_zero, .o_lane_zero_oe, .o_lane_one, .o_lane_one_oe, .o_lane_two,
    .o_lane_two_oe, .o_lane_three, .o_lane_three_oe, .o_cmd_valid, .o_cmd_code, .o_cmd_addr, .i_op_done,
    .o_rd_addr, .i_rd_data, .o_wr_valid, .i_wr_ready, .o_wr_data);
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    i_rd_data <= o_rd_addr[7:0] ^ 8'h5A;
    if (o_cmd_valid === 1'b1) begin
      cmd_cnt   <= cmd_cnt + 1;
      last_code <= o_cmd_code;
      last_addr <= o_cmd_addr;
    end
  end
  task automatic send(input logic [31:0] w, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) host.xfer(w[31-8*i -: 8], d);
  endtask
  task automatic op(input logic [31:0] w, input int n);
    host.sel();
    send(w, n);
    host.desel();
  endtask
  task automatic expect_sr(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] d;
    logic [7:0] v;
    host.sel();
    host.xfer(code, d);
    host.xfer(8'h00, v);
    host.desel();
    `CHK(v, exp)
  endtask
  // leaves select low, in the data phase of a wide read
  task automatic wide(input logic [7:0] code);
    host.sel();
    send({code, 24'h000010}, 4);
    send(32'h0, 2);
    @(negedge i_clk);
  endtask
  task automatic pause_check;
    logic [7:0] d;
    host.sel();
    host.xfer(`OP_RDSR_LOW, d);
    @(posedge i_clk) host.o_sclk <= 1'b0;
    host.tick(8);
    @(posedge i_clk) host.o_hold_n <= 1'b0;
    host.tick(8);
    @(negedge i_clk);
    `CHK(o_lane_one_oe, 1'b0)
    @(posedge i_clk) host.o_hold_n <= 1'b1;
    host.tick(8);
    @(negedge i_clk);
    `CHK(o_lane_one_oe, 1'b1)
    host.desel();
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    give_verdict();
  end
  initial begin
    int n;
    logic [7:0] v0;
    logic [7:0] v1;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    host.tick(8);
    // this write enable lands inside the power-up delay and must be refused
    op({`OP_WREN, 24'h0}, 1);
    expect_sr(`OP_RDSR_LOW, 8'h00);
    op({`OP_WREN, 24'h0}, 1);
    expect_sr(`OP_RDSR_LOW, 8'h02);
    op({`OP_WRDI, 24'h0}, 1);
    expect_sr(`OP_RDSR_LOW, 8'h00);
    $display("test latch done");
    op({`OP_PROG, 24'h000100}, 4);
    `CHK(cmd_cnt, 0)
    op({`OP_WREN, 24'h0}, 1);
    host.sel();
    send({`OP_PROG, 24'h000100}, 4);
    for (int k = 0; k < 9; k++) send({8'h10 + k[7:0], 24'h0}, 1);
    host.desel();
    `CHK(cmd_cnt, 1)
    `CHK(last_code, `OP_PROG)
    `CHK(last_addr, 24'h000100)
    op({`OP_WRDI, 24'h0}, 1);
    op({`OP_SUSPEND, 24'h0}, 1);
    `CHK(cmd_cnt, 2)
    `CHK(last_code, `OP_SUSPEND)
    expect_sr(`OP_RDSR_LOW, 8'h03);
    n = 0;
    @(posedge i_clk) i_wr_ready <= 1'b1;
    repeat (24) begin
      @(negedge i_clk);
      if (o_wr_valid === 1'b1) begin
        `CHK(o_wr_data, 8'h10 + n[7:0])
        n++;
      end
    end
    `CHK(n, 8)
    @(posedge i_clk) i_op_done <= 1'b1;
    @(posedge i_clk) i_op_done <= 1'b0;
    expect_sr(`OP_RDSR_LOW, 8'h00);
    $display("test program done");
    op({`OP_WREN, 24'h0}, 1);
    op({`OP_WRSR, 8'h80, 16'h0}, 2);
    expect_sr(`OP_RDSR_LOW, 8'h80);
    @(posedge i_clk) host.o_wp_n <= 1'b0;
    op({`OP_WREN, 24'h0}, 1);
    op({`OP_WRSR, 8'h1C, 16'h0}, 2);
    expect_sr(`OP_RDSR_LOW, 8'h82);
    @(posedge i_clk) host.o_wp_n <= 1'b1;
    op({`OP_WRSR, 8'h1C, 16'h0}, 2);
    expect_sr(`OP_RDSR_LOW, 8'h1C);
    op({`OP_PDOWN, 24'h0}, 1);
    op({`OP_WREN, 24'h0}, 1);
    op({`OP_PD_REL, 24'h0}, 1);
    expect_sr(`OP_RDSR_LOW, 8'h1C);
    op({`OP_WREN, 24'h0}, 1);
    op({`OP_SEC_ERASE, 24'h001000}, 4);
    `CHK(cmd_cnt, 2)
    expect_sr(`OP_RDSR_LOW, 8'h1E);
    $display("test protect done");
    pause_check();
    // array model answers address xor 5A; the trailing clock fall prefetches a third byte
    host.sel();
    send({`OP_READ, 24'h000010}, 4);
    host.xfer(8'h00, v0);
    host.xfer(8'h00, v1);
    host.desel();
    `CHK(v0, 8'h4A)
    `CHK(v1, 8'h4B)
    `CHK(o_rd_addr, 24'h000013)
    wide(`OP_DUAL_OUT);
    `CHK(o_lane_zero_oe, 1'b1)
    `CHK({o_lane_one, o_lane_zero}, 2'h3)
    host.desel();
    wide(`OP_QUAD_OUT);
    `CHK(o_lane_two_oe, 1'b0)
    host.desel();
    op({`OP_WRSR, 8'h00, 8'h02, 8'h00}, 3);
    expect_sr(`OP_RDSR_HIGH, 8'h02);
    wide(`OP_QUAD_OUT);
    `CHK(o_lane_two_oe, 1'b1)
    `CHK(o_lane_three_oe, 1'b1)
    `CHK({o_lane_three, o_lane_two, o_lane_one, o_lane_zero}, 4'h9)
    host.desel();
    $display("test lanes done");
    give_verdict();
  end
endmodule
